// ---- dv/ubi_bridge_slave_monitor.sv ----
`timescale 1ns/1ps
module ubi_mon #(
  parameter int unsigned LAT_CYCLES = 200
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // bus pins
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_scl_out,
  input wire logic o_scl_oe_n,
  // configuration
  input wire logic i_vsp_option,
  input wire logic i_enum_strobe,
  input wire logic o_vsp_mode,
  // host streams
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_tx_data_present_n,
  input wire logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic [7:0] o_rx_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_scl_never_driven: assert property (o_scl_oe_n && !o_scl_out)
    else $error("clock pin driven");
  a_sda_pulls_low: assert property (!o_sda_out)
    else $error("data pin value not low");
  // data pin may only move while the clock is low, else a false start or stop
  a_sda_moves_low: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
    else $error("data pin changed with clock high");
  a_present_after_push: assert property (
    i_tx_valid && o_tx_ready |-> ##[1:3] !o_tx_data_present_n)
    else $error("present flag not low after host byte");
  a_reset_quiet: assert property (
    $past(i_srst) |-> o_sda_oe_n && o_tx_data_present_n && !o_rx_valid && !o_vsp_mode)
    else $error("outputs not quiet after reset");
  a_rx_holds: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("host byte dropped before taken");
  a_vsp_capture: assert property (i_enum_strobe |=> o_vsp_mode == $past(i_vsp_option))
    else $error("option bit not captured");
  a_vsp_holds: assert property (!i_enum_strobe |=> $stable(o_vsp_mode))
    else $error("option bit changed without enumeration");
endmodule

bind ubi_bridge_slave ubi_mon #(.LAT_CYCLES(LAT_CYCLES)) i_ubi_mon (
  .i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
  .i_vsp_option(i_vsp_option), .i_enum_strobe(i_enum_strobe), .o_vsp_mode(o_vsp_mode),
  .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
  .o_tx_data_present_n(o_tx_data_present_n), .o_rx_valid(o_rx_valid),
  .i_rx_ready(i_rx_ready), .o_rx_data(o_rx_data));

// ---- dv/ubi_bridge_slave_tb.sv ----
`timescale 1ns/1ps
module ubi_bridge_slave_tb
  import ubi_pkg::*;
;
  localparam int LAT = 200;
  localparam logic [6:0] SA = 7'h3A;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic scl_m, sda_m, scl_w, sda_w, sda_out, sda_oe_n, scl_out, scl_oe_n;
  logic vsp = 1'b0;
  logic enum_s = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic rx_hold = 1'b1;
  logic vsp_mode, tx_ready, present_n, rx_valid, a;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data, q, r, rnd;
  logic [7:0] d[3];
  logic [7:0] codes[3] = '{8'h55, CMD_SOFT_RESET, CMD_FLUSH};
  ubi_cfg_s cfg = {1'b0, 3'h0, SA};
  logic [31:0] seed = 32'h60;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int n_ack;
  assign scl_w = scl_m & (scl_oe_n | scl_out);
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  always #5 i_clk = ~i_clk;
  ubi_master_model i_ubi_master_model (.o_scl(scl_m), .o_sda(sda_m), .i_sda(sda_w));
  ubi_bridge_slave #(.LAT_CYCLES(LAT)) i_ubi_bridge_slave (
    .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl_w), .i_sda(sda_w), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n), .i_cfg(cfg),
    .i_vsp_option(vsp), .i_enum_strobe(enum_s), .o_vsp_mode(vsp_mode),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data),
    .o_tx_data_present_n(present_n), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .o_rx_data(rx_data));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task push(input logic [7:0] v);
    int n;
    @(negedge i_clk);
    tx_valid = 1'b1;
    tx_data = v;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 50);
    @(negedge i_clk);
    tx_valid = 1'b0;
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
  endtask
  task wb(input logic [7:0] v, output logic ack);
    i_ubi_master_model.xfer(v, 1'b1, q, ack);
  endtask
  task rb(input logic mack, output logic [7:0] v);
    i_ubi_master_model.xfer(8'hFF, mack, v, a);
  endtask
  task gc(input logic [7:0] code);
    i_ubi_master_model.start();
    wb(GCALL_ADDR, a);
    check(8'(a), 8'h00);
    wb(code, a);
    check(8'(a), 8'h00);
    i_ubi_master_model.stop();
  endtask
  task drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // host side stalls at random while not held off
  always @(negedge i_clk) begin
    rnd = xs();
    rx_ready <= !rx_hold & rnd[0];
  end
  always @(posedge i_clk) begin
    if (!i_srst && rx_valid && rx_ready) begin
      if (exp_q.size() != 0) begin
        check(rx_data, exp_q.pop_front());
      end else begin
        fail_count++;
        $display("[FAIL] %0t stray host byte", $time);
      end
    end
  end
  initial begin
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    vsp = 1'b1;
    enum_s = 1'b1;
    @(negedge i_clk);
    enum_s = 1'b0;
    vsp = 1'b0;
    @(negedge i_clk);
    check(8'(vsp_mode), 8'h01);
    i_ubi_master_model.start();
    wb({SA, 1'b1}, a);
    check(8'(a), 8'h01);
    i_ubi_master_model.stop();
    for (int k = 0; k < 3; k++) begin
      d[k] = xs();
      push(d[k]);
    end
    repeat (3) @(negedge i_clk);
    check(8'(present_n), 8'h00);
    gc(CMD_DATA_AVAIL);
    i_ubi_master_model.start();
    wb({SA, 1'b1}, a);
    check(8'(a), 8'h00);
    rb(1'b0, r);
    check(r, 8'h03);
    for (int k = 0; k < 3; k++) begin
      rb(k == 2, r);
      check(r, d[k]);
    end
    i_ubi_master_model.stop();
    repeat (4) @(negedge i_clk);
    check(8'(present_n), 8'h01);
    // fill the receive side with the host stalled, then drain it
    i_ubi_master_model.start();
    wb({SA, 1'b0}, a);
    check(8'(a), 8'h00);
    n_ack = 0;
    for (int k = 0; k < 12; k++) begin
      r = xs();
      wb(r, a);
      if (a === 1'b0) begin
        n_ack++;
        exp_q.push_back(r);
      end
    end
    i_ubi_master_model.stop();
    check(8'(n_ack > 7 && n_ack < 10), 8'h01);
    i_ubi_master_model.start();
    wb({SA, 1'b0}, a);
    check(8'(a), 8'h01);
    i_ubi_master_model.stop();
    rx_hold = 1'b0;
    drain();
    // unknown code keeps everything, reset and flush empty both sides
    foreach (codes[k]) begin
      push(xs());
      r = xs();
      i_ubi_master_model.start();
      wb({SA, 1'b0}, a);
      wb(r, a);
      i_ubi_master_model.stop();
      gc(codes[k]);
      if (codes[k] == 8'h55) begin
        exp_q.push_back(r);
      end
      repeat (4) @(negedge i_clk);
      check(8'(present_n), (codes[k] == 8'h55) ? 8'h00 : 8'h01);
      drain();
      repeat (LAT + 100) @(negedge i_clk);
    end
    cfg = {1'b1, 10'h2B5};
    d[0] = xs();
    push(d[0]);
    i_ubi_master_model.start();
    wb({TEN_BIT_PREFIX, cfg.addr[9:8], 1'b0}, a);
    check(8'(a), 8'h00);
    wb(cfg.addr[7:0], a);
    check(8'(a), 8'h00);
    r = xs();
    wb(r, a);
    check(8'(a), 8'h00);
    exp_q.push_back(r);
    // let the slave drop its acknowledge first, else the start looks like a stop
    repeat (4) @(negedge i_clk);
    i_ubi_master_model.start();
    wb({TEN_BIT_PREFIX, cfg.addr[9:8], 1'b1}, a);
    check(8'(a), 8'h00);
    rb(1'b1, r);
    check(r, d[0]);
    i_ubi_master_model.stop();
    drain();
    close_out();
  end
endmodule

// ---- dv/ubi_master_model.sv ----
`timescale 1ns/1ps
module ubi_master_model (
  // open-drain levels, 1 = released
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // works from high idle and from clock low, so it also gives a repeated start
  task automatic start();
    o_sda = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b0;
    #20 o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda = 1'b1;
    #40;
  endtask
  // 80 ns bit, low 55+5 ns so the slave's late answer settles before the rise
  task automatic bit_x(input logic b, output logic r);
    o_sda = b;
    #55 o_scl = 1'b1;
    #10 r = i_sda;
    #10 o_scl = 1'b0;
    #5;
  endtask
  // write: d = byte, ack bit released; read: d = 8'hFF, ack bit = master answer
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(mack, ack);
  endtask
endmodule

// ---- src/ubi_bridge_slave.sv ----
`timescale 1ns/1ps
// What this block does
// - answer as slave to the configured address, in 7-bit or 10-bit form
// - slave address comes from the nonvolatile configuration memory input
// - acknowledge general call, take the second byte as a command
// - general call software reset is supported beside own commands
// - active-low pin low whenever the transmit buffer holds a byte
// - read address is refused when the transmit buffer is empty and no data-available command is pending
// - after data-available command, the next read returns the byte count
// - the count is one byte saturating at its maximum
// - written bytes go to the host when buffer fills or timer expires
// - host bytes are queued and handed to the master as plain payload
// - the clock line is never driven
// - host serial line settings do not touch the bus side
// - virtual serial port option is read at each enumeration and reported
// - soft reset command empties all data buffers
// - flush command empties both transmit and receive buffers
// - write address or data byte is refused when the buffer has no room

////////////////////////////////////////////////////////////////////////////////
module ubi_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_flush,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [$clog2(D):0] o_count
);
  localparam int unsigned AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic push;
  logic pop;

  assign o_ready = (o_count != FULL);
  assign o_valid = (o_count != '0);
  assign o_data = mem[rp];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // depth is a power of two so the pointers wrap on their own
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || i_flush) begin
      wp <= '0;
      rp <= '0;
      o_count <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      if (push && !pop) begin
        o_count <= o_count + 1'b1;
      end else if (pop && !push) begin
        o_count <= o_count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ubi_bridge_slave
  import ubi_pkg::*;
#(
  parameter int unsigned LAT_CYCLES = LATENCY_CYCLES
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // bus pins, open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  // nonvolatile configuration
  input wire ubi_cfg_s i_cfg,
  input wire logic i_vsp_option,
  input wire logic i_enum_strobe,
  output logic o_vsp_mode,
  // host to master stream
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_data_present_n,
  // master to host stream
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [7:0] o_rx_data
);
  localparam int unsigned CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] TX_HIGH = CW'(FIFO_DEPTH - 1);

  logic scl_m, scl_s, scl_q;
  logic sda_m, sda_s, sda_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  ubi_state_e state;
  ubi_kind_e kind;
  logic [3:0] bitcnt;
  logic [7:0] sh;
  logic [7:0] tx_sh;
  logic rd_go, ten_match, avail_pending, flush;
  logic tx_pop, rx_push;
  logic [7:0] rx_byte;
  logic tx_f_valid, rx_f_valid, rx_f_ready, rx_drain, release_rx;
  logic [7:0] tx_f_data, rx_f_data;
  logic [CW-1:0] tx_count;
  logic [31:0] lat_cnt;
  logic hit7, hit10, want_rd, want_wr, want_10, rd_ok;
  logic [7:0] rd_byte;

  function automatic logic [7:0] sat_count(input logic [15:0] c);
    return (c > 16'(AVAIL_MAX)) ? AVAIL_MAX : c[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pins sampled on our clock; bit timing follows only the master's clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

  // clock pin is released for good, we never stretch
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe_n <= 1'b1;
    end else begin
      o_sda_out <= 1'b0;
      o_scl_out <= 1'b0;
      o_scl_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address match against the configured address
  assign hit7 = !i_cfg.ten_bit && (sh[7:1] == i_cfg.addr[6:0]);
  assign hit10 = i_cfg.ten_bit && (sh[7:3] == TEN_BIT_PREFIX) &&
                 (sh[2:1] == i_cfg.addr[9:8]);
  assign want_rd = sh[0] && (hit7 || (hit10 && ten_match));
  assign want_wr = !sh[0] && hit7;
  assign want_10 = !sh[0] && hit10;
  // count is snapped at the address phase and pops nothing
  assign rd_ok = avail_pending | tx_f_valid;
  assign rd_byte = avail_pending ? sat_count(16'(tx_count)) : tx_f_data;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      kind <= K_ADDR;
      bitcnt <= 4'h0;
      sh <= 8'h00;
      tx_sh <= 8'hFF;
      o_sda_oe_n <= 1'b1;
      rd_go <= 1'b0;
      ten_match <= 1'b0;
      avail_pending <= 1'b0;
      flush <= 1'b0;
      tx_pop <= 1'b0;
      rx_push <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      tx_pop <= 1'b0;
      rx_push <= 1'b0;
      flush <= 1'b0;
      if (stop_c) begin
        state <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
        ten_match <= 1'b0;
      end else if (start_c) begin
        // a repeated start keeps the 10-bit match for the read that follows
        state <= ST_RECV;
        kind <= K_ADDR;
        bitcnt <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else begin
        unique case (state)
          ST_IDLE: begin
          end
          ST_RECV: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
              bitcnt <= 4'h0;
              state <= ST_ACK;
              rd_go <= 1'b0;
              unique case (kind)
                K_ADDR: begin
                  if (sh == GCALL_ADDR) begin
                    o_sda_oe_n <= 1'b0;
                    kind <= K_GCALL;
                  end else if (want_rd && rd_ok) begin
                    o_sda_oe_n <= 1'b0;
                    rd_go <= 1'b1;
                    tx_sh <= rd_byte;
                    tx_pop <= ~avail_pending;
                    avail_pending <= 1'b0;
                  end else if (want_wr && rx_f_ready) begin
                    o_sda_oe_n <= 1'b0;
                    kind <= K_WDATA;
                  end else if (want_10) begin
                    o_sda_oe_n <= 1'b0;
                    kind <= K_ADDR10;
                  end
                end
                K_ADDR10: begin
                  ten_match <= (sh == i_cfg.addr[7:0]);
                  if (sh == i_cfg.addr[7:0] && rx_f_ready) begin
                    o_sda_oe_n <= 1'b0;
                    kind <= K_WDATA;
                  end
                end
                K_GCALL: begin
                  o_sda_oe_n <= 1'b0;
                  unique case (sh)
                    CMD_SOFT_RESET: flush <= 1'b1;
                    CMD_FLUSH: flush <= 1'b1;
                    CMD_DATA_AVAIL: avail_pending <= 1'b1;
                    default: begin
                    end
                  endcase
                end
                K_WDATA: begin
                  if (rx_f_ready) begin
                    o_sda_oe_n <= 1'b0;
                    rx_push <= 1'b1;
                    rx_byte <= sh;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_go && !o_sda_oe_n) begin
                o_sda_oe_n <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b1};
                bitcnt <= 4'h1;
                state <= ST_SEND;
              end else begin
                o_sda_oe_n <= 1'b1;
                bitcnt <= 4'h0;
                state <= o_sda_oe_n ? ST_IDLE : ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bitcnt == BITS_PER_BYTE) begin
                o_sda_oe_n <= 1'b1;
                bitcnt <= 4'h0;
                state <= ST_MACK;
              end else begin
                o_sda_oe_n <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b1};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                // an empty buffer mid-burst gives filler the master cannot tell apart
                tx_sh <= tx_f_valid ? tx_f_data : IDLE_BYTE;
                tx_pop <= tx_f_valid;
                state <= ST_SEND;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host side: line settings have no port here, only the payload crosses
  ubi_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_flush(flush),
    .i_valid(i_tx_valid & o_tx_ready),
    .o_ready(),
    .i_data(i_tx_data),
    .o_valid(tx_f_valid),
    .i_ready(tx_pop),
    .o_data(tx_f_data),
    .o_count(tx_count)
  );

  ubi_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_flush(flush),
    .i_valid(rx_push),
    .o_ready(rx_f_ready),
    .i_data(rx_byte),
    .o_valid(rx_f_valid),
    .i_ready(rx_drain),
    .o_data(rx_f_data),
    .o_count()
  );

  // ready leaves one spare slot because it is a cycle late
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_tx_ready <= 1'b0;
      o_tx_data_present_n <= 1'b1;
    end else begin
      o_tx_ready <= (tx_count < TX_HIGH);
      o_tx_data_present_n <= (tx_count == '0);
    end
  end

  // receive data is held until full or the latency timer runs out
  always_ff @(posedge i_clk) begin
    if (i_srst || flush) begin
      lat_cnt <= 32'h0;
      release_rx <= 1'b0;
    end else if (!rx_f_valid) begin
      lat_cnt <= 32'h0;
      release_rx <= 1'b0;
    end else if (!rx_f_ready || lat_cnt >= 32'(LAT_CYCLES - 1)) begin
      release_rx <= 1'b1;
    end else if (!release_rx) begin
      lat_cnt <= lat_cnt + 32'h1;
    end
  end

  assign rx_drain = release_rx & (~o_rx_valid | i_rx_ready);

  always_ff @(posedge i_clk) begin
    if (i_srst || flush) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end else if (!o_rx_valid || i_rx_ready) begin
      o_rx_valid <= release_rx & rx_f_valid;
      o_rx_data <= rx_f_data;
    end
  end

  // option bit reported per enumeration, not followed live
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_vsp_mode <= 1'b0;
    end else if (i_enum_strobe) begin
      o_vsp_mode <= i_vsp_option;
    end
  end
endmodule

// ---- src/ubi_pkg.sv ----
package ubi_pkg;

  // byte and buffer geometry
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // address phase
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  // general-call command codes
  localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
  localparam logic [7:0] CMD_FLUSH = 8'h0E;
  localparam logic [7:0] CMD_DATA_AVAIL = 8'h0C;

  // count reply ceiling and filler byte once the transmit buffer runs dry
  localparam logic [7:0] AVAIL_MAX = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  // latency timer
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned LATENCY_US = 16000;
  localparam int unsigned LATENCY_CYCLES = LATENCY_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_MACK
  } ubi_state_e;

  typedef enum logic [1:0] {
    K_ADDR,
    K_ADDR10,
    K_GCALL,
    K_WDATA
  } ubi_kind_e;

  typedef struct packed {
    logic ten_bit;
    logic [9:0] addr;
  } ubi_cfg_s;

endpackage
